/* hdl/bwps_pattern_source.sv */
// Pattern word registers, bit sequencers and AHB-Lite slave
//
// Implementation choices: register access over AHB-Lite and the address map.
`default_nettype none
module bwps_pattern_source #(
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              srst,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Pattern stream to the transmit path
   output logic                   gen_bit,
   // Reference stream for the receive checker
   input  wire logic              chk_advance,
   input  wire logic              chk_restart,
   output logic                   chk_bit,
   // Settings seen by the rest of the tester
   output logic [1:0]             pattern_select,
   output logic [3:0]             pattern_length_field,
   output logic [7:0]             alternate_repeat_count
);

   // Decode needs byte address bits up to 9; refuse narrower buses
   if (ADDR_W < 10) begin : g_addr_w_check
      $error("ADDR_W must be at least 10");
   end

   // One step of the shared sequencer; both streams use this
   function automatic bwps_pkg::bwps_seq_t seq_next(
      input bwps_pkg::bwps_seq_t s,
      input logic [1:0]          mode,
      input logic [3:0]          len,
      input logic [7:0]          count
   );
      bwps_pkg::bwps_seq_t n;
      logic [4:0]          last;
      n    = s;
      last = bwps_pkg::REP_LAST_BASE + {1'b0, len};
      if (mode == bwps_pkg::BWPS_MODE_ALT) begin
         n.pos = s.pos + 5'h01;
         if (s.pos >= bwps_pkg::WORD_LAST) begin
            n.pos = 5'h00;
            n.rep = s.rep + 8'h01;
            if (s.rep >= count) begin
               n.rep      = 8'h00;
               n.word_sel = ~s.word_sel;
            end
         end
      end else if (mode == bwps_pkg::BWPS_MODE_REP) begin
         // Count ignored; wrap at programmed last bit
         n.word_sel = 1'b0;
         n.rep      = 8'h00;
         n.pos      = (s.pos >= last) ? 5'h00 : s.pos + 5'h01;
      end else begin
         n = '0;
      end
      return n;
   endfunction : seq_next

   // Bit under the sequencer; second word is offset by sixteen
   function automatic logic seq_bit(
      input bwps_pkg::bwps_seq_t s,
      input logic [31:0]         pat,
      input logic [1:0]          mode
   );
      logic [4:0] sel;
      sel = s.word_sel ? s.pos + 5'(bwps_pkg::WORD_BITS) : s.pos;
      if (mode != bwps_pkg::BWPS_MODE_REP && mode != bwps_pkg::BWPS_MODE_ALT) begin
         return 1'b0; // Unused select code behaves as off
      end
      return pat[sel];
   endfunction : seq_bit

   // Register state
   logic [31:0]          pattern_q, pattern_d;
   logic [7:0]           repeat_q, repeat_d;
   logic [1:0]           mode_q, mode_d;
   logic [3:0]           len_q, len_d;
   bwps_pkg::bwps_addr_t aph_q, aph_d;
   logic [31:0]          rdata_q, rdata_d;
   logic                 restart;
   bwps_pkg::bwps_seq_t  gen_seq_q, gen_seq_d, chk_seq_q, chk_seq_d;

   // Bus decode and register writes, read data from next values except status, which reads the current gen_seq_q
   always_comb begin
      pattern_d = pattern_q;
      repeat_d  = repeat_q;
      mode_d    = mode_q;
      len_d     = len_q;
      restart   = 1'b0;
      if (aph_q.valid && aph_q.write) begin
         case (aph_q.idx)
            bwps_pkg::IDX_PATTERN_0: pattern_d[7:0]   = hwdata[7:0];
            bwps_pkg::IDX_PATTERN_1: pattern_d[15:8]  = hwdata[7:0];
            bwps_pkg::IDX_PATTERN_2: pattern_d[23:16] = hwdata[7:0];
            bwps_pkg::IDX_PATTERN_3: pattern_d[31:24] = hwdata[7:0];
            bwps_pkg::IDX_REPEAT:    repeat_d = hwdata[7:0];
            bwps_pkg::IDX_CTRL: begin
               // New selection starts both streams at the first word
               mode_d  = hwdata[bwps_pkg::CTRL_MODE_LSB +: 2];
               len_d   = hwdata[bwps_pkg::CTRL_LEN_LSB +: 4];
               restart = 1'b1;
            end
            default: ;
         endcase
      end
      aph_d.valid = hsel && hready && htrans[1];
      aph_d.write = hwrite;
      aph_d.idx   = haddr[9:2];
      rdata_d     = 32'h0000_0000;
      if (aph_d.valid && !hwrite && haddr[ADDR_W-1:10] == '0) begin
         case (aph_d.idx)
            bwps_pkg::IDX_PATTERN_0: rdata_d[7:0] = pattern_d[7:0];
            bwps_pkg::IDX_PATTERN_1: rdata_d[7:0] = pattern_d[15:8];
            bwps_pkg::IDX_PATTERN_2: rdata_d[7:0] = pattern_d[23:16];
            bwps_pkg::IDX_PATTERN_3: rdata_d[7:0] = pattern_d[31:24];
            bwps_pkg::IDX_REPEAT:    rdata_d[7:0] = repeat_d;
            bwps_pkg::IDX_CTRL:      rdata_d[7:0] = {len_d, 2'b00, mode_d};
            bwps_pkg::IDX_STATUS:    rdata_d[13:0] = gen_seq_q;
            default:                 rdata_d = 32'h0000_0000;
         endcase
      end
      if (haddr[ADDR_W-1:10] != '0) begin
         aph_d.valid = 1'b0; // Unmapped: writes dropped, reads zero
      end
   end

   // Register bank; zero wait states, always OKAY
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pattern_q <= bwps_pkg::PATTERN_RST;
         repeat_q  <= bwps_pkg::REPEAT_RST;
         mode_q    <= bwps_pkg::MODE_RST;
         len_q     <= bwps_pkg::LEN_RST;
         aph_q     <= '0;
         rdata_q   <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         pattern_q <= pattern_d;
         repeat_q  <= repeat_d;
         mode_q    <= mode_d;
         len_q     <= len_d;
         aph_q     <= aph_d;
         rdata_q   <= rdata_d;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata = rdata_q;

   // Sequencers: generator runs every clock, checker on its advance
   logic                gen_bit_d, chk_bit_d;

   always_comb begin
      gen_bit_d = seq_bit(gen_seq_q, pattern_q, mode_q);
      gen_seq_d = seq_next(gen_seq_q, mode_q, len_q, repeat_q);
      chk_bit_d = chk_bit;
      chk_seq_d = chk_seq_q;
      if (chk_advance) begin
         // Checker walks the very same sequence
         chk_bit_d = seq_bit(chk_seq_q, pattern_q, mode_q);
         chk_seq_d = seq_next(chk_seq_q, mode_q, len_q, repeat_q);
      end
      if (restart) begin
         gen_seq_d = '0;
         chk_seq_d = '0;
      end
      if (chk_restart) begin
         // Slip back to the first word so the checker can relock
         chk_seq_d = '0;
      end
   end

   // Stream registers; outputs come straight from these
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gen_seq_q <= '0;
         chk_seq_q <= '0;
         gen_bit   <= 1'b0;
         chk_bit   <= 1'b0;
      end else begin
         gen_seq_q <= gen_seq_d;
         chk_seq_q <= chk_seq_d;
         gen_bit   <= gen_bit_d;
         chk_bit   <= chk_bit_d;
      end
   end

   assign pattern_select         = mode_q;
   assign pattern_length_field   = len_q;
   assign alternate_repeat_count = repeat_q;

   // Checks
   sequence s_alt_word0_start;
      mode_q == bwps_pkg::BWPS_MODE_ALT && !restart && !gen_seq_q.word_sel
         && gen_seq_q.pos == 5'h00;
   endsequence
   sequence s_alt_word1_start;
      mode_q == bwps_pkg::BWPS_MODE_ALT && !restart && gen_seq_q.word_sel
         && gen_seq_q.pos == 5'h00;
   endsequence

   chk_alt_first_lsb: assert property (@(posedge sys_clk) disable iff (srst)
      s_alt_word0_start |=> gen_bit == $past(pattern_q[0]))
      else $error("first word did not start with bit 0");

   chk_alt_second_lsb: assert property (@(posedge sys_clk) disable iff (srst)
      s_alt_word1_start |=> gen_bit == $past(pattern_q[16]))
      else $error("second word did not start with bit 16");

   chk_alt_half_select: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_ALT && gen_seq_q.word_sel)
      |=> gen_bit == $past(pattern_q[16 + 32'(gen_seq_q.pos[3:0])]))
      else $error("second word bit not from upper half");

   chk_rep_wrap_len: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_REP && !restart
       && gen_seq_q.pos == bwps_pkg::REP_LAST_BASE + {1'b0, len_q})
      |=> gen_seq_q.pos == 5'h00 ##1 gen_bit == $past(pattern_q[0]))
      else $error("repetition did not wrap at programmed length");

   chk_rep_no_early: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_REP && !restart && gen_seq_q.pos != 5'h00
       && gen_seq_q.pos < bwps_pkg::REP_LAST_BASE + {1'b0, len_q})
      |=> gen_seq_q.pos == $past(gen_seq_q.pos) + 5'h01)
      else $error("repetition wrapped early");

   chk_alt_word_count: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_ALT && !restart && $stable(mode_q) && !$past(restart)
       && gen_seq_q.word_sel != $past(gen_seq_q.word_sel))
      |-> $past(gen_seq_q.rep) == $past(repeat_q) && $past(gen_seq_q.pos) == 5'h0F)
      else $error("word switched before count plus one repeats");

   chk_checker_same: assert property (@(posedge sys_clk) disable iff (srst)
      (chk_advance && !chk_restart && !restart && chk_seq_q == gen_seq_q)
      |=> chk_bit == gen_bit && chk_seq_q == gen_seq_q)
      else $error("checker sequence differs from generator");

   chk_byte_assembly: assert property (@(posedge sys_clk) disable iff (srst)
      (aph_q.valid && aph_q.write && aph_q.idx == bwps_pkg::IDX_PATTERN_1)
      |=> pattern_q[15:8] == $past(hwdata[7:0])
          && pattern_q[7:0] == $past(pattern_q[7:0]))
      else $error("pattern byte 1 not stored in bits 15 to 8");

   // Last bit of an alternating word, outside a restart
   sequence s_alt_word_end;
      mode_q == bwps_pkg::BWPS_MODE_ALT && !restart && gen_seq_q.pos == bwps_pkg::WORD_LAST;
   endsequence

   chk_alt_word_stay: assert property (@(posedge sys_clk) disable iff (srst)
      (s_alt_word_end ##0 (gen_seq_q.rep < repeat_q))
      |=> gen_seq_q.word_sel == $past(gen_seq_q.word_sel)
          && gen_seq_q.rep == $past(gen_seq_q.rep) + 8'h01 && gen_seq_q.pos == 5'h00)
      else $error("word left before its repeats were done");

   chk_alt_word_swap: assert property (@(posedge sys_clk) disable iff (srst)
      (s_alt_word_end ##0 (gen_seq_q.rep == repeat_q))
      |=> gen_seq_q.word_sel != $past(gen_seq_q.word_sel)
          && gen_seq_q.rep == 8'h00 && gen_seq_q.pos == 5'h00)
      else $error("other word did not follow the last repeat");

   chk_alt_low_half: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_ALT && !gen_seq_q.word_sel)
      |=> gen_bit == $past(pattern_q[32'(gen_seq_q.pos[3:0])]))
      else $error("first word bit not from lower half");

   chk_rep_count_ignored: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == bwps_pkg::BWPS_MODE_REP && !restart)
      |=> gen_seq_q.rep == 8'h00 && !gen_seq_q.word_sel)
      else $error("repeat count used in repetitive mode");

   chk_restart_both_zero: assert property (@(posedge sys_clk) disable iff (srst)
      restart |=> gen_seq_q == '0 && chk_seq_q == '0)
      else $error("selection write did not restart both sequences");

   chk_reset_zero: assert property (@(posedge sys_clk)
      srst |=> pattern_q == bwps_pkg::PATTERN_RST && repeat_q == bwps_pkg::REPEAT_RST
               && gen_bit == 1'b0 && chk_bit == 1'b0)
      else $error("reset did not clear pattern and streams");

   chk_byte_upper: assert property (@(posedge sys_clk) disable iff (srst)
      (aph_q.valid && aph_q.write && aph_q.idx == bwps_pkg::IDX_PATTERN_3)
      |=> pattern_q[31:24] == $past(hwdata[7:0])
          && pattern_q[23:0] == $past(pattern_q[23:0]))
      else $error("pattern byte 3 not stored in bits 31 to 24");

   chk_off_quiet: assert property (@(posedge sys_clk) disable iff (srst) // Off and unused codes
      (mode_q != bwps_pkg::BWPS_MODE_REP && mode_q != bwps_pkg::BWPS_MODE_ALT)
      |=> gen_bit == 1'b0)
      else $error("generator not quiet while off");

endmodule : bwps_pattern_source
`default_nettype wire

/* hdl/bwps_pkg.sv */
// Constants and types shared by the pattern-word source block
`default_nettype none
package bwps_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL      = 8'h30;
   localparam logic [7:0] IDX_REPEAT    = 8'h33;
   localparam logic [7:0] IDX_STATUS    = 8'h39;
   localparam logic [7:0] IDX_PATTERN_0 = 8'h3C;
   localparam logic [7:0] IDX_PATTERN_1 = 8'h3D;
   localparam logic [7:0] IDX_PATTERN_2 = 8'h3E;
   localparam logic [7:0] IDX_PATTERN_3 = 8'h3F;
   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LEN_LSB  = 4;
   // Reset values
   localparam logic [31:0] PATTERN_RST = 32'h0000_0000;
   localparam logic [7:0]  REPEAT_RST  = 8'h00;
   localparam logic [1:0]  MODE_RST    = 2'h0;
   localparam logic [3:0]  LEN_RST     = 4'h0;
   // Word geometry
   localparam logic [4:0] WORD_LAST     = 5'h0F;
   localparam int         WORD_BITS     = 16;
   localparam logic [4:0] REP_LAST_BASE = 5'h10;
   // Pattern selection
   typedef enum logic [1:0] {
      BWPS_MODE_OFF = 2'h0,
      BWPS_MODE_REP = 2'h1,
      BWPS_MODE_ALT = 2'h2
   } bwps_mode_t;
   // Sequencer position
   typedef struct packed {
      logic       word_sel;
      logic [4:0] pos;
      logic [7:0] rep;
   } bwps_seq_t;
   // Captured AHB address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] idx;
   } bwps_addr_t;
endpackage : bwps_pkg
`default_nettype wire

/* sim/bwps_host_model.sv */
// Host processor model: AHB-Lite master issuing single word transfers
`default_nettype none
module bwps_host_model (
   // Clock and slave answer
   input  wire logic        sys_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Master request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Bounded wait for hready high at a rising edge
   task automatic wait_rdy(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 40 && ok !== 1'b1; n++) begin
         @(posedge sys_clk);
         ok = hready;
      end
   endtask : wait_rdy
   // One transfer; called at a rising edge, returns at the data phase edge
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      wait_rdy(ok);
      if (ok !== 1'b1) return;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(ok);
      rd = hrdata;
   endtask : xfer
endmodule : bwps_host_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the pattern word source
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [31:0] pat;
      logic [1:0]  mode;
      logic [3:0]  len;
      logic [7:0]  cnt;
      int          nb;
   } bwps_row_t;
   logic        sys_clk, srst, hsel, hwrite, hready, hresp, gen_bit, chk_bit;
   logic        chk_advance, chk_restart;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, pattern_select;
   logic [2:0]  hsize;
   logic [3:0]  pattern_length_field;
   logic [7:0]  alternate_repeat_count;
   int          error_cnt, num_checks, per;
   // Pattern, mode, length, repeat count, bits to walk
   bwps_row_t   rows[8] = '{'{32'hA5C3_1E69, 2'h2, 4'h0, 8'h00, 64},
      '{32'hA5C3_1E69, 2'h2, 4'h0, 8'h02, 192}, '{32'h8001_F00D, 2'h2, 4'h0, 8'hFF, 8224},
      '{32'h0001_2C35, 2'h1, 4'h0, 8'h00, 40}, '{32'hC0DE_4B17, 2'h1, 4'hF, 8'h00, 70},
      '{32'h00F3_9A61, 2'h1, 4'h7, 8'h00, 50}, '{32'hFFFF_FFFF, 2'h0, 4'h0, 8'h00, 20},
      '{32'h1234_5679, 2'h3, 4'h5, 8'h11, 20}};

   bwps_pattern_source dut_u (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .gen_bit(gen_bit),
      .chk_advance(chk_advance), .chk_restart(chk_restart), .chk_bit(chk_bit),
      .pattern_select(pattern_select), .pattern_length_field(pattern_length_field),
      .alternate_repeat_count(alternate_repeat_count));
   bwps_host_model host_u (.sys_clk(sys_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Expected bit k of a row's sequence, counted from word 0 bit 0
   function automatic logic exp_bit(bwps_row_t r, int k);
      int w;
      w = 16 * (r.cnt + 1);
      if (r.mode == 2'h2) return r.pat[((k % (2 * w)) >= w) * 16 + k % 16];
      if (r.mode == 2'h1) return r.pat[k % (r.len + 17)];
      return 1'b0;
   endfunction : exp_bit
   function automatic logic [31:0] ba(logic [7:0] i);
      return {22'h0, i, 2'h0};
   endfunction : ba
   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // Bus access; a hung handshake ends the run
   task automatic bus(logic [31:0] a, logic w, logic [31:0] d, output logic [31:0] r);
      logic ok;
      host_u.xfer(a, w, d, r, ok);
      if (ok !== 1'b1) begin
         error_cnt++;
         give_verdict();
      end
   endtask : bus
   task automatic rd_chk(string what, logic [31:0] a, logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      check(what, e, r);
   endtask : rd_chk
   // Reset, then outputs and registers at zero
   task automatic do_reset();
      srst <= 1'b1;
      chk_advance <= 1'b0;
      chk_restart <= 1'b0;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check("gen_bit reset", 32'h0, 32'(gen_bit));
      check("pattern_select reset", 32'h0, 32'(pattern_select));
      check("hresp reset", 32'h0, 32'(hresp));
      @(posedge sys_clk);
      for (int j = 0; j < 4; j++) rd_chk("pattern reset", ba(8'h3C + 8'(j)), 32'h0);
      rd_chk("repeat reset", ba(bwps_pkg::IDX_REPEAT), 32'h0);
      rd_chk("status reset", ba(bwps_pkg::IDX_STATUS), 32'h0);
   endtask : do_reset
   // Generator: some phase of two periods must match the expected sequence
   task automatic gen_stream(bwps_row_t r, int p);
      logic [127:0] got;
      logic         m, hit;
      hit = 1'b0;
      for (int k = 0; k < 2 * p; k++) begin
         @(posedge sys_clk);
         #1 got[k] = gen_bit;
      end
      for (int o = 0; o < p; o++) begin
         m = 1'b1;
         for (int k = 0; k < p; k++) if (got[o + k] !== exp_bit(r, k)) m = 1'b0;
         if (m) hit = 1'b1;
      end
      check("gen_bit sequence", 32'h1, 32'(hit));
      @(posedge sys_clk);
   endtask : gen_stream
   // Checker reference: restart together with advance, then step every cycle
   task automatic chk_stream(bwps_row_t r);
      chk_restart <= 1'b1;
      chk_advance <= 1'b1;
      @(posedge sys_clk);
      chk_restart <= 1'b0;
      for (int k = 0; k < r.nb; k++) begin
         @(posedge sys_clk);
         #1 check("chk_bit", 32'(exp_bit(r, k)), 32'(chk_bit));
      end
      @(posedge sys_clk);
      chk_advance <= 1'b0;
   endtask : chk_stream

   // Main sequence; pattern is always loaded before the mode is selected
   initial begin
      logic [31:0] r, a;
      logic [7:0]  c;
      error_cnt = 0;
      num_checks = 0;
      do_reset();
      foreach (rows[i]) begin
         // Stop the old pattern before loading a new word and count
         bus(ba(bwps_pkg::IDX_CTRL), 1'b1, 32'h0, r);
         for (int j = 0; j < 4; j++) begin
            a = ba(bwps_pkg::IDX_PATTERN_0 + 8'(j));
            bus(a, 1'b1, 32'hFFFF_FF00 | 32'(rows[i].pat[8*j+:8]), r);
         end
         for (int j = 0; j < 4; j++) begin
            a = ba(bwps_pkg::IDX_PATTERN_0 + 8'(j));
            rd_chk("pattern byte", a, 32'(rows[i].pat[8*j+:8]));
         end
         bus(ba(bwps_pkg::IDX_REPEAT), 1'b1, 32'(rows[i].cnt), r);
         // Checker steps alongside the generator from the restart on
         chk_advance <= 1'b1;
         c = {rows[i].len, 2'h0, rows[i].mode};
         bus(ba(bwps_pkg::IDX_CTRL), 1'b1, 32'(c), r);
         rd_chk("control", ba(bwps_pkg::IDX_CTRL), 32'(c));
         #1 check("pattern_select", 32'(rows[i].mode), 32'(pattern_select));
         check("length field", 32'(rows[i].len), 32'(pattern_length_field));
         check("repeat count", 32'(rows[i].cnt), 32'(alternate_repeat_count));
         @(posedge sys_clk);
         per = 1;
         if (rows[i].mode == 2'h2) per = 32 * (rows[i].cnt + 1);
         if (rows[i].mode == 2'h1) per = rows[i].len + 17;
         if (per <= 64) gen_stream(rows[i], per);
         chk_stream(rows[i]);
      end
      bus(32'h0000_04F0, 1'b1, 32'h55, r);
      rd_chk("unmapped write", ba(8'h3C), 32'h79);
      rd_chk("unmapped read", 32'h0000_04F0, 32'h0);
      do_reset();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
